// ---- hw/lane_a2_config_regs.v ----
/*
  Configuration and status register slice for lane A2 of the repeater,
  reached through the SMBus slave's internal register port.
  Assumes the SMBus slave decodes bus frames into single-cycle read and write
  strobes on core_clk, and that the analog lane logic consumes the outputs.
*/
// Operation
// - Swing register bit 7 enables short-circuit protection when one.
// - Swing bits 2:0 pick output/input ratio; reset code 101.
// - De-emphasis bit 7 is read-only receiver-detect status: one means terminated.
// - De-emphasis bits 2:0 pick 0 to -12 dB; reset code 010.
// - Threshold bits 3:2 set signal-detect assert level; reset 00.
// - Threshold bits 1:0 set signal-detect de-assert level; reset 00.
// - Threshold fields apply only when global bit 6 is set, else pin.
// - Lane receiver-detect setting overrides pin only when global bit 3 set.
`timescale 1ns/1ps
`default_nettype none
`include "lane_a2_map.vh"
module lane_a2_config_regs (
  // Clock, reset, enable
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clk_en,
  // Register port from the SMBus slave
  input  wire       slave_mode,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  // Global control bits from register 0x08
  input  wire       global_sd_ovr,
  input  wire       global_receiver_detect_ovr,
  // Pin and analog inputs
  input  wire [3:0] sd_threshold_pin,
  input  wire [1:0] receiver_detect_pin,
  input  wire [1:0] receiver_detect_lane_setting,
  input  wire       receiver_detect_raw,
  // Analog lane controls
  output reg        short_protect_en,
  output reg  [2:0] output_swing,
  output reg  [2:0] output_deemphasis,
  output reg  [1:0] sd_assert_level,
  output reg  [1:0] sd_deassert_level,
  output reg  [1:0] receiver_detect_mode
);
  // Stored register images
  reg  [7:0] swing_q;
  reg  [7:0] deemph_q;
  reg  [7:0] thresh_q;
  reg  [7:0] rsvd_3e_q;
  reg  [7:0] rsvd_3f_q;

  // Synchronised pin and status views
  wire [5:0] pin_raw;
  wire [5:0] pin_sync;
  wire [3:0] sd_pin_q;
  wire [1:0] receiver_detect_pin_q;
  wire       rx_detect_sync;

  // Access qualifiers and per-register write enables
  wire       access_ok;
  wire       wr_ok;
  wire       rd_ok;
  wire       wr_swing;
  wire       wr_deemph;
  wire       wr_thresh;
  wire       wr_rsvd_3e;
  wire       wr_rsvd_3f;
  reg  [7:0] rdata_d;
  genvar     gi;

  // Termination status comes from analog timing, so resynchronise it
  sync2 u_receiver_detect_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (receiver_detect_raw),
    .sync_out (rx_detect_sync)
  );

  // Pins are asynchronous straps; one two-flop stage per pin bit
  assign pin_raw = {receiver_detect_pin, sd_threshold_pin};

  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pin_sync
      sync2 u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in (pin_raw[gi]),
        .sync_out (pin_sync[gi])
      );
    end
  endgenerate

  // Low nibble is the threshold strap, top pair the rx-detect strap
  assign sd_pin_q    = pin_sync[3:0];
  assign receiver_detect_pin_q = pin_sync[5:4];

  // Strobes outside slave mode are dropped, not queued
  assign access_ok = clk_en & slave_mode;
  assign wr_ok     = access_ok & reg_wr;
  assign rd_ok     = access_ok & reg_rd;

  // Address decode kept apart from storage so the mux below stays flat
  assign wr_swing   = wr_ok & (reg_addr == `ADDR_OUTPUT_SWING);
  assign wr_deemph  = wr_ok & (reg_addr == `ADDR_DEEMPH_DETECT);
  assign wr_thresh  = wr_ok & (reg_addr == `ADDR_DETECT_THRESHOLD);
  assign wr_rsvd_3e = wr_ok & (reg_addr == `ADDR_RESERVED_3E);
  assign wr_rsvd_3f = wr_ok & (reg_addr == `ADDR_RESERVED_3F);

  // Reserved bits are stored as written; software keeps the pattern
  always @(posedge core_clk) begin
    if (rst) begin
      swing_q <= `RST_OUTPUT_SWING;
    end else if (wr_swing) begin
      swing_q <= reg_wdata;
    end
  end

  // Bit 7 is status only; its storage flop is held at zero
  always @(posedge core_clk) begin
    if (rst) begin
      deemph_q <= `RST_DEEMPH_DETECT;
    end else if (wr_deemph) begin
      deemph_q <= reg_wdata & `MASK_DEEMPH_WRITABLE;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      thresh_q <= `RST_DETECT_THRESHOLD;
    end else if (wr_thresh) begin
      thresh_q <= reg_wdata;
    end
  end

  // Reserved registers read back what was written, as plain storage
  always @(posedge core_clk) begin
    if (rst) begin
      rsvd_3e_q <= `RST_RESERVED;
      rsvd_3f_q <= `RST_RESERVED;
    end else begin
      if (wr_rsvd_3e) begin
        rsvd_3e_q <= reg_wdata;
      end
      if (wr_rsvd_3f) begin
        rsvd_3f_q <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets read zero so other slices can OR their data in
  always @* begin
    case (reg_addr)
      `ADDR_OUTPUT_SWING:     rdata_d = swing_q;
      `ADDR_DEEMPH_DETECT:    rdata_d = {rx_detect_sync, deemph_q[6:0]};
      `ADDR_DETECT_THRESHOLD: rdata_d = thresh_q;
      `ADDR_RESERVED_3E:      rdata_d = rsvd_3e_q;
      `ADDR_RESERVED_3F:      rdata_d = rsvd_3f_q;
      default:                rdata_d = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      // Idle data is zero so the slave can OR slices together
      reg_rvalid <= rd_ok;
      reg_rdata  <= rd_ok ? rdata_d : 8'h00;
    end
  end

  // Analog controls, registered so every output comes from a flop
  always @(posedge core_clk) begin
    if (rst) begin
      short_protect_en     <= 1'b1;
      output_swing         <= 3'h5;
      output_deemphasis    <= 3'h2;
      sd_assert_level      <= 2'h0;
      sd_deassert_level    <= 2'h0;
      receiver_detect_mode <= 2'h0;
    end else if (clk_en) begin
      short_protect_en  <= swing_q[`BIT_SHORT_PROTECT];
      output_swing      <= swing_q[2:0];
      output_deemphasis <= deemph_q[2:0];
      // Global select is on this clock already; no sync needed
      if (global_sd_ovr) begin
        sd_assert_level   <= thresh_q[3:2];
        sd_deassert_level <= thresh_q[1:0];
      end else begin
        sd_assert_level   <= sd_pin_q[3:2];
        sd_deassert_level <= sd_pin_q[1:0];
      end
      // Lane setting only wins while the global override is set
      if (global_receiver_detect_ovr) begin
        receiver_detect_mode <= receiver_detect_lane_setting;
      end else begin
        receiver_detect_mode <= receiver_detect_pin_q;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/sync2.v ----
/*
  Two-flop synchroniser for one level input.
  Assumes the input is asynchronous to core_clk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  // Clock and control
  input  wire core_clk,
  input  wire rst,
  input  wire clk_en,
  // Data
  input  wire async_in,
  output reg  sync_out
);
  reg meta_q;

  always @(posedge core_clk) begin
    if (rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- include/lane_a2_map.vh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  lane A2 configuration slice. Assumes an 8-bit register address space.
*/
`ifndef LANE_A2_MAP_VH
`define LANE_A2_MAP_VH

// Register offsets
`define ADDR_OUTPUT_SWING     8'h3b
`define ADDR_DEEMPH_DETECT    8'h3c
`define ADDR_DETECT_THRESHOLD 8'h3d
`define ADDR_RESERVED_3E      8'h3e
`define ADDR_RESERVED_3F      8'h3f

// Reset values
`define RST_OUTPUT_SWING      8'had
`define RST_DEEMPH_DETECT     8'h02
`define RST_DETECT_THRESHOLD  8'h00
`define RST_RESERVED          8'h00

// Field positions
`define BIT_SHORT_PROTECT     7
`define BIT_RX_DETECT_STATUS  7
`define BIT_GLOBAL_SD_OVR     6
`define BIT_GLOBAL_RECEIVER_DETECT_OVR  3

// Swing register keeps bits 7:0 writable; de-emphasis keeps 6:0 writable
`define MASK_DEEMPH_WRITABLE  8'h7f

// Read data appears this many cycles after the read strobe
`define READ_LATENCY_CYCLES   1

`endif

// ---- testbench/lane_regs_props.sv ----
/* Port checker for the lane A2 register slice.
   Assumes single-cycle strobes on core_clk and synchronous reset rst. */
`timescale 1ns/1ps
`default_nettype none
module lane_regs_props (
  // Clock and control
  input wire logic       core_clk, rst, clk_en, slave_mode, reg_wr, reg_rd, reg_rvalid,
  input wire logic       global_sd_ovr, global_receiver_detect_ovr, receiver_detect_raw, short_protect_en,
  // Data
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [3:0] sd_threshold_pin,
  input wire logic [2:0] output_swing, output_deemphasis,
  input wire logic [1:0] receiver_detect_lane_setting, sd_assert_level, sd_deassert_level,
  input wire logic [1:0] receiver_detect_mode
);
  logic [7:0] wd1_q, wd2_q;
  always @(posedge core_clk) begin
    wd1_q <= reg_wdata;
    wd2_q <= wd1_q;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence wr_at(a);
    clk_en && slave_mode && reg_wr && reg_addr == a;
  endsequence
  sequence rd_go;
    clk_en && slave_mode && reg_rd;
  endsequence
  rd_answer_a: assert property (rd_go |=> reg_rvalid)
    else $error("read got no answer");
  unmapped_rd_a: assert property (rd_go ##0 (reg_addr < 8'h3b) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  swing_wr_a: assert property (wr_at(8'h3b) ##1 clk_en |=>
    {short_protect_en, output_swing} == {wd2_q[7], wd2_q[2:0]}) else $error("swing not applied");
  deemph_wr_a: assert property (wr_at(8'h3c) ##1 clk_en |=>
    output_deemphasis == wd2_q[2:0]) else $error("deemphasis not applied");
  status_rd_a: assert property ((clk_en && $stable(receiver_detect_raw)) [*4] ##0 rd_go
    ##0 reg_addr == 8'h3c |=> reg_rdata[7] == $past(receiver_detect_raw)) else $error("bad status");
  thresh_wr_a: assert property (wr_at(8'h3d) ##1 (clk_en && global_sd_ovr) |=>
    {sd_assert_level, sd_deassert_level} == wd2_q[3:0]) else $error("threshold not applied");
  pin_path_a: assert property ((clk_en && !global_sd_ovr && $stable(sd_threshold_pin)) [*4] |=>
    {sd_assert_level, sd_deassert_level} == $past(sd_threshold_pin)) else $error("pin ignored");
  receiver_detect_ovr_a: assert property (clk_en && global_receiver_detect_ovr |=>
    receiver_detect_mode == $past(receiver_detect_lane_setting)) else $error("lane setting ignored");
endmodule
bind lane_a2_config_regs lane_regs_props lane_regs_props_inst (.*);
`default_nettype wire

// ---- testbench/repeater_lane_config_regs_test.sv ----
/* Self-checking bench for the lane A2 register slice.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module repeater_lane_config_regs_test;
  logic core_clk, rst, clk_en, slave_mode, global_sd_ovr, global_receiver_detect_ovr, receiver_detect_raw, v;
  logic [3:0] sd_threshold_pin;
  logic [1:0] receiver_detect_pin, receiver_detect_lane_setting;
  logic [7:0] q;
  logic [7:0] rv [5] = '{8'had, 8'h02, 8'h00, 8'h00, 8'h00};
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, short_protect_en;
  wire [2:0] output_swing, output_deemphasis;
  wire [1:0] sd_assert_level, sd_deassert_level, receiver_detect_mode;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  lane_a2_config_regs lane_a2_config_regs_inst (.*);
  smbus_host_model smbus_host_model_inst (.*);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, exp, input logic vexp);
    smbus_host_model_inst.rd(a, q, v);
    chk({7'h0, v}, {7'h0, vexp});
    if (vexp) chk(q, exp);
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) if (++cycles == 3000) begin
    n_mismatch++;
    wrap_up;
  end
  initial begin
    {rst, clk_en, slave_mode, global_sd_ovr, global_receiver_detect_ovr, receiver_detect_raw} = 6'h38;
    {sd_threshold_pin, receiver_detect_pin, receiver_detect_lane_setting} = 8'h00;
    repeat (5) @(negedge core_clk);
    rst = 0;
    for (int i = 0; i < 5; i++) rdchk(8'(8'h3b + i), rv[i], 1);
    chk({short_protect_en, output_deemphasis, 1'b0, output_swing}, 8'ha5);
    smbus_host_model_inst.wr(8'h3b, 8'h2e);
    rdchk(8'h3b, 8'h2e, 1);
    chk({short_protect_en, 4'h0, output_swing}, 8'h06);
    smbus_host_model_inst.wr(8'h3b, 8'haf);
    smbus_host_model_inst.wr(8'h3c, 8'h87);
    rdchk(8'h3c, 8'h07, 1);
    chk({short_protect_en, output_deemphasis, 1'b0, output_swing}, 8'hf7);
    receiver_detect_raw = 1;
    repeat (3) @(negedge core_clk);
    rdchk(8'h3c, 8'h87, 1);
    global_sd_ovr = 1;
    smbus_host_model_inst.wr(8'h3d, 8'h0b);
    rdchk(8'h3d, 8'h0b, 1);
    chk({4'h0, sd_assert_level, sd_deassert_level}, 8'h0b);
    {global_sd_ovr, sd_threshold_pin, global_receiver_detect_ovr, receiver_detect_lane_setting, receiver_detect_pin} = 10'h0d9;
    repeat (5) @(negedge core_clk);
    chk({2'h0, sd_assert_level, sd_deassert_level, receiver_detect_mode}, 8'h1a);
    global_receiver_detect_ovr = 0;
    repeat (5) @(negedge core_clk);
    chk({6'h0, receiver_detect_mode}, 8'h01);
    clk_en = 0;
    smbus_host_model_inst.wr(8'h3b, 8'h2d);
    clk_en = 1;
    rdchk(8'h3b, 8'haf, 1);
    slave_mode = 0;
    smbus_host_model_inst.wr(8'h3b, 8'h2d);
    rdchk(8'h3b, 8'h00, 0);
    slave_mode = 1;
    rdchk(8'h3b, 8'haf, 1);
    rdchk(8'h30, 8'h00, 1);
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- testbench/smbus_host_model.sv ----
/* Host side of the register port: single-byte write and read cycles.
   Assumes the slice answers a read one edge after the strobe. */
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input wire logic       core_clk, reg_rvalid,
  input wire logic [7:0] reg_rdata,
  output logic           reg_wr, reg_rd,
  output logic [7:0]     reg_addr, reg_wdata
);
  initial begin
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Callers keep reserved bits 0101 or zero
  task automatic wr(input logic [7:0] a, d);
    @(negedge core_clk) reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk) reg_wr = 0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(negedge core_clk) reg_addr = a;
    reg_rd = 1;
    // The answer stands for one cycle only; take it before dropping the strobe
    @(negedge core_clk) v = reg_rvalid;
    q = reg_rdata;
    reg_rd = 0;
    reg_addr = ~a;
  endtask
endmodule
`default_nettype wire
